// file: common/fdc_pkg.sv
// constants and types of the frequency data cycle controller
package fdc_pkg;
  localparam int          DIGIT_W    = 4;
  localparam int          DIGITS     = 8;
  localparam int          WORD_W     = 32;
  localparam int          ADDR_W     = 4;
  localparam int          CNT_W      = 4;
  localparam int          RES_W      = 3;
  localparam int          NNUM_W     = 12;
  localparam int          MNUM_W     = 20;
  localparam int          DAC_W      = 16;
  // copy phase: eight digit shifts plus one clock latching the decode
  localparam logic [3:0]  COPY_CLKS  = 4'h9;
  localparam logic [3:0]  DIV_CLKS   = 4'h8;
  localparam logic [3:0]  DIGIT_MAX  = 4'h9;
  // register offsets (byte addresses)
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_STAT   = 4'h4;
  localparam logic [3:0]  OFF_FREQ   = 4'h8;
  localparam logic [3:0]  OFF_TUNE   = 4'hc;
  // control field layout and reset value
  localparam int          CTRL_RES_LSB = 0;
  localparam int          CTRL_TEST_BIT = 3;
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  // frequency limits and band edges, packed decimal in kHz
  localparam logic [31:0] FREQ_MIN   = 32'h02000000;
  localparam logic [31:0] FREQ_MAX   = 32'h18000000;
  localparam logic [31:0] BAND1_TOP  = 32'h06200000;
  localparam logic [31:0] BAND2_TOP  = 32'h12400000;
  localparam logic [1:0]  BAND_1     = 2'h1;
  localparam logic [1:0]  BAND_2     = 2'h2;
  localparam logic [1:0]  BAND_3     = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DIVIDE, ST_DECIDE}
    fdc_state_e;
endpackage

// file: rtl/fdc_div_digit.sv
// one decimal digit step of the divide-by-band-number chain
`timescale 1ns/1ns
module fdc_div_digit
  import fdc_pkg::*;
(
  input  wire logic [1:0]         rem_i,
  input  wire logic [DIGIT_W-1:0] digit_i,
  input  wire logic [1:0]         divisor_i,
  output wire logic [DIGIT_W-1:0] quot_o,
  output wire logic [1:0]         rem_o
);
  wire logic [4:0] part_w;
  wire logic [4:0] div_w;
  wire logic [4:0] q_w;
  wire logic [4:0] r_w;

  // partial dividend stays at or below 29 for decimal digits, so five bits suffice
  assign part_w = 5'(rem_i) * 5'h0a + 5'(digit_i);
  assign div_w  = (divisor_i == 2'h0) ? 5'h01 : 5'(divisor_i);
  assign q_w    = part_w / div_w;
  assign r_w    = part_w % div_w;
  assign quot_o = q_w[DIGIT_W-1:0];
  assign rem_o  = r_w[1:0];
endmodule // fdc_div_digit

// file: rtl/fdc_loop_decode.sv
// tuning register decode into loop divider numbers and pretune word
`timescale 1ns/1ns
module fdc_loop_decode
  import fdc_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              load_i,
  input  wire logic [WORD_W-1:0] tune_i,
  output logic      [NNUM_W-1:0] n_num_o,
  output logic      [MNUM_W-1:0] m_num_o,
  output logic      [MNUM_W-1:0] lsl_word_o,
  output logic      [DAC_W-1:0]  dac_word_o
);
  // digits above 100 MHz set the main divider, the rest the fine loop
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      n_num_o    <= '0;
      m_num_o    <= '0;
      lsl_word_o <= '0;
      dac_word_o <= '0;
    end else if (load_i) begin
      n_num_o    <= tune_i[31:20];
      m_num_o    <= tune_i[19:0];
      lsl_word_o <= tune_i[19:0];
      dac_word_o <= tune_i[31:16];
    end
  end
endmodule // fdc_loop_decode

// file: rtl/fdc_cycle_ctrl.sv
// frequency data cycle datapath and sequencer
`timescale 1ns/1ns
module fdc_cycle_ctrl
  import fdc_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [WORD_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [WORD_W-1:0] rdata_o,
  input  wire logic              enc_a_i,
  input  wire logic              enc_b_i,
  input  wire logic              test_cycle_i,
  output logic      [WORD_W-1:0] display_o,
  output logic      [1:0]        band_o,
  output logic                   err_o,
  output logic                   busy_o,
  output logic      [NNUM_W-1:0] n_num_o,
  output logic      [MNUM_W-1:0] m_num_o,
  output logic      [MNUM_W-1:0] lsl_word_o,
  output logic      [DAC_W-1:0]  dac_word_o
);
  fdc_state_e        state_reg;
  fdc_state_e        state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [WORD_W-1:0] work_reg;
  logic [WORD_W-1:0] div_reg;
  logic [WORD_W-1:0] quot_reg;
  logic [WORD_W-1:0] tune_reg;
  logic [WORD_W-1:0] remote_reg;
  logic [3:0]        ctrl_reg;
  logic              carry_reg;
  logic [1:0]        rem_reg;
  logic              enc_a_reg;
  logic              knob_pend_reg;
  logic              knob_dir_reg;
  logic              remote_pend_reg;
  logic              retry_reg;
  logic              retry_res_reg;
  logic              dir_reg;
  logic              step_en_reg;
  logic [RES_W-1:0]  step_pos_reg;
  logic              tune_load_reg;

  // register decode
  wire logic              wr_ctrl_w;
  wire logic              wr_freq_w;
  wire logic              knob_evt_w;
  wire logic              knob_up_w;
  wire logic              start_w;
  wire logic              take_remote_w;
  wire logic              take_knob_w;
  wire logic [RES_W-1:0]  res_sel_w;
  wire logic              test_en_w;
  wire logic [DIGIT_W-1:0] in_digit_w;
  wire logic              hit_w;
  wire logic              cin_w;
  wire logic [DIGIT_W-1:0] sum_w;
  wire logic              cout_w;
  wire logic              err_low_w;
  wire logic              err_high_w;
  wire logic              err_w;
  wire logic [1:0]        band_w;
  wire logic [DIGIT_W-1:0] q_digit_w;
  wire logic [1:0]        rem_next_w;
  wire logic              shift_last_w;
  wire logic              div_last_w;
  wire logic [WORD_W-1:0] rd_mux_w;
  wire logic [WORD_W-1:0] status_w;

  assign wr_ctrl_w = wr_i && (addr_i == OFF_CTRL);
  assign wr_freq_w = wr_i && (addr_i == OFF_FREQ);
  assign res_sel_w = ctrl_reg[CTRL_RES_LSB +: RES_W];
  assign test_en_w = ctrl_reg[CTRL_TEST_BIT] | test_cycle_i;

  // knob: a rising phase-a edge is one detent, phase b gives the sense
  assign knob_evt_w = enc_a_i && !enc_a_reg;
  assign knob_up_w  = !enc_b_i;

  // a start takes remote first, then retries, then knob, then test mode
  assign start_w = (state_reg == ST_IDLE) &&
                   (remote_pend_reg || retry_reg || knob_pend_reg ||
                    test_en_w);
  assign take_remote_w = start_w && remote_pend_reg;
  assign take_knob_w   = start_w && !remote_pend_reg && !retry_reg &&
                         knob_pend_reg;

  // digit-serial plus/minus one adder, lowest digit leaves first
  assign in_digit_w = work_reg[DIGIT_W-1:0];
  assign hit_w  = step_en_reg && (cnt_reg == 4'(step_pos_reg));
  assign cin_w  = hit_w | carry_reg;
  assign sum_w  = !cin_w ? in_digit_w :
                  dir_reg ? ((in_digit_w == DIGIT_MAX) ? 4'h0 :
                             in_digit_w + 4'h1) :
                            ((in_digit_w == 4'h0) ? DIGIT_MAX :
                             in_digit_w - 4'h1);
  assign cout_w = cin_w && (dir_reg ? (in_digit_w == DIGIT_MAX) :
                                      (in_digit_w == 4'h0));

  // range and band decode of the stored word; packed decimal orders
  // the same as binary, so plain compares work
  assign err_low_w  = work_reg < FREQ_MIN;
  assign err_high_w = work_reg > FREQ_MAX;
  assign err_w      = err_low_w | err_high_w;
  assign band_w = (work_reg <= BAND1_TOP) ? BAND_1 :
                  (work_reg <= BAND2_TOP) ? BAND_2 : BAND_3;

  assign shift_last_w = (state_reg == ST_SHIFT) &&
                        (cnt_reg == COPY_CLKS - 4'h1);
  assign div_last_w   = (state_reg == ST_DIVIDE) &&
                        (cnt_reg == DIV_CLKS - 4'h1);

  // divider walks the copied word highest digit first
  fdc_div_digit u_div (
    .rem_i     (rem_reg),
    .digit_i   (div_reg[WORD_W-1 -: DIGIT_W]),
    .divisor_i (band_o),
    .quot_o    (q_digit_w),
    .rem_o     (rem_next_w)
  );

  assign status_w = {24'h000000, 2'h0, rem_reg != 2'h0, retry_reg,
                     band_o, err_o, busy_o};
  assign rd_mux_w = (addr_i == OFF_CTRL) ? {28'h0000000, ctrl_reg} :
                    (addr_i == OFF_STAT) ? status_w :
                    (addr_i == OFF_FREQ) ? work_reg :
                    (addr_i == OFF_TUNE) ? tune_reg : 32'h00000000;

  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:   if (start_w) state_next = ST_SHIFT;
      ST_SHIFT:  if (shift_last_w) state_next = ST_DIVIDE;
      ST_DIVIDE: if (div_last_w) state_next = ST_DECIDE;
      ST_DECIDE: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? '0 : cnt_reg + 4'h1;
    end
  end

  // bus registers and read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl_reg   <= CTRL_RST;
      rdata_o    <= '0;
      remote_reg <= '0;
      enc_a_reg  <= 1'b0;
    end else begin
      enc_a_reg <= enc_a_i;
      rdata_o   <= rd_i ? rd_mux_w : '0;
      if (wr_ctrl_w) ctrl_reg <= wdata_i[3:0];
      if (wr_freq_w) remote_reg <= wdata_i;
    end
  end

  // pending requests: a new arrival wins over the clear at start
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      remote_pend_reg <= 1'b0;
      knob_pend_reg   <= 1'b0;
      knob_dir_reg    <= 1'b0;
    end else begin
      if (wr_freq_w) remote_pend_reg <= 1'b1;
      else if (take_remote_w) remote_pend_reg <= 1'b0;
      if (knob_evt_w) begin
        knob_pend_reg <= 1'b1;
        knob_dir_reg  <= knob_up_w;
      end else if (take_knob_w) begin
        knob_pend_reg <= 1'b0;
      end
    end
  end

  // step setup at start; remainder retries keep the last sense, range retries step back into range
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dir_reg      <= 1'b1;
      step_en_reg  <= 1'b0;
      step_pos_reg <= '0;
    end else if (start_w) begin
      if (remote_pend_reg) begin
        step_en_reg <= 1'b0;
      end else if (retry_reg) begin
        step_en_reg  <= 1'b1;
        step_pos_reg <= retry_res_reg ? res_sel_w : '0;
        if (err_low_w) dir_reg <= 1'b1;
        else if (err_high_w) dir_reg <= 1'b0;
      end else if (knob_pend_reg) begin
        step_en_reg  <= 1'b1;
        step_pos_reg <= res_sel_w;
        dir_reg      <= knob_dir_reg;
      end else begin
        step_en_reg <= 1'b0;
      end
    end
  end

  // working register is kept through reset; it is never cleared here
  always_ff @(posedge sys_clk_i) begin
    if (take_remote_w) begin
      work_reg <= remote_reg;
    end else if (state_reg == ST_SHIFT && cnt_reg < DIV_CLKS) begin
      work_reg <= {sum_w, work_reg[WORD_W-1:DIGIT_W]};
    end
  end

  // adder carry, divider copy and display shift in lockstep
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      carry_reg <= 1'b0;
      div_reg   <= '0;
      display_o <= '0;
      quot_reg  <= '0;
      rem_reg   <= '0;
      err_o     <= 1'b0;
      band_o    <= BAND_1;
    end else begin
      if (state_reg == ST_SHIFT && cnt_reg < DIV_CLKS) begin
        carry_reg <= cout_w;
        div_reg   <= {sum_w, div_reg[WORD_W-1:DIGIT_W]};
        display_o <= {sum_w, display_o[WORD_W-1:DIGIT_W]};
      end else begin
        carry_reg <= 1'b0;
      end
      if (shift_last_w) begin
        err_o   <= err_w;
        band_o  <= band_w;
        rem_reg <= 2'h0;
      end
      if (state_reg == ST_DIVIDE) begin
        div_reg  <= {div_reg[WORD_W-DIGIT_W-1:0], 4'h0};
        quot_reg <= {quot_reg[WORD_W-DIGIT_W-1:0], q_digit_w};
        rem_reg  <= rem_next_w;
      end
    end
  end

  // decision after division
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      retry_reg     <= 1'b0;
      retry_res_reg <= 1'b0;
      tune_load_reg <= 1'b0;
      tune_reg      <= '0;
      busy_o        <= 1'b0;
    end else begin
      busy_o        <= state_next != ST_IDLE;
      tune_load_reg <= 1'b0;
      if (start_w) retry_reg <= 1'b0;
      if (state_reg == ST_DECIDE) begin
        if (err_o) begin
          retry_reg     <= 1'b1;
          retry_res_reg <= 1'b1;
        end else if (rem_reg != 2'h0) begin
          retry_reg     <= 1'b1;
          retry_res_reg <= 1'b0;
        end else begin
          tune_reg      <= quot_reg;
          tune_load_reg <= 1'b1;
        end
      end
    end
  end

  fdc_loop_decode u_loop (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .load_i     (tune_load_reg),
    .tune_i     (tune_reg),
    .n_num_o    (n_num_o),
    .m_num_o    (m_num_o),
    .lsl_word_o (lsl_word_o),
    .dac_word_o (dac_word_o)
  );
endmodule // fdc_cycle_ctrl

// file: test/fdc_knob_model.sv
// tuning knob model: one detent per turn request
`timescale 1ns/1ns
module fdc_knob_model (
  input  wire logic sys_clk_i,
  input  wire logic turn_i,
  input  wire logic ccw_i,
  output wire logic enc_a_o,
  output wire logic enc_b_o
);
  logic [2:0] cnt_reg = 3'h0;
  logic       a_reg   = 1'b0;
  logic       b_reg   = 1'b0;
  // phase b settles before phase a rises, as a real detent does
  always @(posedge sys_clk_i) begin
    if (turn_i) begin
      cnt_reg <= 3'h1;
      b_reg   <= ccw_i;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
    a_reg <= (cnt_reg >= 3'h2) && (cnt_reg <= 3'h5);
  end
  assign enc_a_o = a_reg;
  assign enc_b_o = b_reg;
endmodule // fdc_knob_model

// file: test/fdc_cycle_ctrl_properties.sv
// port assertions of the data cycle controller
`timescale 1ns/1ns
module fdc_cycle_ctrl_properties
  import fdc_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [WORD_W-1:0] rdata_o,
  input wire logic              test_cycle_i,
  input wire logic [1:0]        band_o,
  input wire logic              err_o,
  input wire logic              busy_o,
  input wire logic [NNUM_W-1:0] n_num_o,
  input wire logic [MNUM_W-1:0] m_num_o,
  input wire logic [MNUM_W-1:0] lsl_word_o,
  input wire logic [DAC_W-1:0]  dac_word_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire mapped;
  assign mapped = addr_i inside {OFF_CTRL, OFF_STAT, OFF_FREQ, OFF_TUNE};
  sequence s_run8;
    busy_o [*8];
  endsequence
  property p_cycle_len;
    $rose(busy_o) |-> s_run8 ##1 s_run8 ##1 busy_o [*2] ##1 !busy_o;
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("data cycle length wrong");
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_unmapped;
    rd_i && !mapped |=> rdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_status;
    rd_i && addr_i == OFF_STAT |=>
      rdata_o[3:0] == {$past(band_o), $past(err_o), $past(busy_o)};
  endproperty
  a_status: assert property (p_status)
    else $error("status word wrong");
  property p_band_ok;
    band_o != 2'h0;
  endproperty
  a_band_ok: assert property (p_band_ok)
    else $error("band number out of set");
  property p_latch;
    // reset itself may move band and error back to their idle values
    !$past(reset_i) && ($changed(band_o) || $changed(err_o)) |-> busy_o;
  endproperty
  a_latch: assert property (p_latch)
    else $error("band or error moved outside a cycle");
  property p_err_retry;
    $fell(busy_o) && err_o |-> ##[1:4] busy_o;
  endproperty
  a_err_retry: assert property (p_err_retry)
    else $error("no retry after error");
  property p_test;
    test_cycle_i && !busy_o |-> ##[1:4] busy_o;
  endproperty
  a_test: assert property (p_test)
    else $error("test mode not cycling");
  property p_remote;
    wr_i && addr_i == OFF_FREQ && !busy_o |-> ##[1:3] busy_o;
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote word did not start a cycle");
  property p_loop;
    n_num_o == dac_word_o[15:4] && m_num_o == lsl_word_o;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop words disagree");
endmodule // fdc_cycle_ctrl_properties
bind fdc_cycle_ctrl fdc_cycle_ctrl_properties u_props (
  .sys_clk_i, .reset_i, .addr_i, .wr_i, .rd_i, .rdata_o, .test_cycle_i,
  .band_o, .err_o, .busy_o, .n_num_o, .m_num_o, .lsl_word_o, .dac_word_o
);

// file: test/fdc_cycle_ctrl_tb.sv
// self-checking bench of the data cycle controller
`timescale 1ns/1ns
module fdc_cycle_ctrl_tb
  import fdc_pkg::*;
();
  logic              sys_clk_i;
  logic              reset_i = 1'b1;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic              test_cycle_i = 1'b0;
  logic              turn = 1'b0;
  logic              ccw = 1'b0;
  logic [ADDR_W-1:0] addr_i = 4'h0;
  logic [WORD_W-1:0] wdata_i = 32'h0;
  logic [WORD_W-1:0] rdata_o, display_o;
  logic [1:0]        band_o;
  logic              err_o, busy_o, enc_a_i, enc_b_i;
  logic [NNUM_W-1:0] n_num_o;
  logic [MNUM_W-1:0] m_num_o, lsl_word_o;
  logic [DAC_W-1:0]  dac_word_o;
  int                fail_count = 0;
  int                checked = 0;
  int                n;
  logic [31:0] f_tab [4] = '{32'h03000000, 32'h06200000, 32'h10000000,
                             32'h15000000};
  logic [31:0] t_tab [4] = '{32'h03000000, 32'h06200000, 32'h05000000,
                             32'h05000000};
  logic [1:0]  b_tab [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  fdc_knob_model u_knob (.sys_clk_i, .turn_i(turn), .ccw_i(ccw),
                         .enc_a_o(enc_a_i), .enc_b_o(enc_b_i));
  fdc_cycle_ctrl dut (.sys_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .enc_a_i, .enc_b_i, .test_cycle_i, .display_o, .band_o, .err_o,
    .busy_o, .n_num_o, .m_num_o, .lsl_word_o, .dac_word_o);
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    wr_i    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1 cmp(rdata_o, exp);
  endtask
  // idle means several quiet cycles, since retries leave short gaps
  task automatic wait_idle();
    int q;
    int k;
    q = 0;
    for (k = 0; q < 6; k++) begin
      @(posedge sys_clk_i);
      #1 q = (busy_o === 1'b0) ? q + 1 : 0;
      if (k > 2000) begin
        fail_count++;
        summarize();
      end
    end
  endtask
  task automatic knob(input logic c);
    @(posedge sys_clk_i);
    turn <= 1'b1;
    ccw  <= c;
    @(posedge sys_clk_i);
    turn <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    wait_idle();
  endtask
  task automatic knob_case(input logic [31:0] res, input logic [31:0] f0,
                           input logic c, input logic [31:0] f1,
                           input logic [31:0] t1);
    wr(OFF_CTRL, res);
    wr(OFF_FREQ, f0);
    wait_idle();
    knob(c);
    rdc(OFF_FREQ, f1);
    rdc(OFF_TUNE, t1);
  endtask
  task automatic pulse_reset();
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rdc(OFF_CTRL, 32'h0);
    rdc(4'h2, 32'h0);
    cmp({30'h0, band_o}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FREQ, f_tab[i]);
      wait_idle();
      rdc(OFF_TUNE, t_tab[i]);
      rdc(OFF_STAT, {28'h0, b_tab[i], 2'h0});
      cmp(display_o, f_tab[i]);
      cmp({n_num_o, m_num_o}, t_tab[i]);
      cmp({dac_word_o, lsl_word_o[15:0]}, t_tab[i]);
    end
    wr(OFF_CTRL, 32'h7);
    rdc(OFF_CTRL, 32'h7);
    wr(OFF_FREQ, 32'h01000000);
    wait_idle();
    rdc(OFF_FREQ, 32'h11000000);
    rdc(OFF_TUNE, 32'h05500000);
    knob_case(32'h0, 32'h10000000, 1'b0, 32'h10000002, 32'h05000001);
    knob_case(32'h3, 32'h15000000, 1'b1, 32'h14998998, 32'h04999666);
    wr(OFF_FREQ, 32'h03000000);
    wr(OFF_FREQ, 32'h10000000);
    wait_idle();
    rdc(OFF_FREQ, 32'h10000000);
    rdc(OFF_TUNE, 32'h05000000);
    @(posedge sys_clk_i);
    test_cycle_i <= 1'b1;
    n = 0;
    repeat (100) begin
      @(posedge sys_clk_i);
      #1 if (busy_o === 1'b1) n++;
    end
    @(posedge sys_clk_i);
    test_cycle_i <= 1'b0;
    cmp({31'h0, n > 60}, 32'h1);
    wr(OFF_CTRL, 32'h8);
    n = 0;
    repeat (100) begin
      @(posedge sys_clk_i);
      #1 if (busy_o === 1'b1) n++;
    end
    wr(OFF_CTRL, 32'h0);
    cmp({31'h0, n > 60}, 32'h1);
    wait_idle();
    rdc(OFF_FREQ, 32'h10000000);
    pulse_reset();
    rdc(OFF_FREQ, 32'h10000000);
    rdc(OFF_CTRL, 32'h0);
    wr(OFF_FREQ, 32'h06200000);
    repeat (5) @(posedge sys_clk_i);
    pulse_reset();
    cmp({31'h0, busy_o}, 32'h0);
    wr(OFF_FREQ, 32'h03000000);
    wait_idle();
    rdc(OFF_TUNE, 32'h03000000);
    summarize();
  end
endmodule // fdc_cycle_ctrl_tb
